//--- design/lmfr_pkg.sv
package lmfr_pkg;

	// ****************************************
	// Bus and register geometry
	// ****************************************
	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;
	localparam int REG_W = 16;
	localparam int IDX_W = 10;
	localparam int NUM_ROUTE_REGS = 6;
	localparam int NUM_TAPS = 12;
	localparam int NUM_PAIRS = 8;
	localparam int GROUP_SIZE = 4;
	localparam int TAP_VAL_W = 12;
	localparam int CODE_W = 4;
	localparam int GATE_BIT = 15;
	localparam int SELECT_BIT = 15;

	// ****************************************
	// Register indices, byte address is four times the index
	// ****************************************
	localparam logic [9:0] IDX_LANE_ROUTE_PAIRS_ONE_TWO = 10'h050;
	localparam logic [9:0] IDX_LANE_ROUTE_PAIR_THREE = 10'h051;
	localparam logic [9:0] IDX_LANE_ROUTE_PAIR_FOUR = 10'h052;
	localparam logic [9:0] IDX_LANE_ROUTE_PAIR_FIVE = 10'h053;
	localparam logic [9:0] IDX_LANE_ROUTE_PAIRS_SIX_SEVEN = 10'h054;
	localparam logic [9:0] IDX_LANE_ROUTE_PAIR_EIGHT = 10'h055;
	localparam logic [9:0] IDX_CHAN1_FILTER_TAP_0 = 10'h05A;
	localparam logic [9:0] IDX_CHAN1_FILTER_TAP_11 = 10'h065;
	localparam logic [9:0] IDX_CHAN2_FILTER_TAP_0 = 10'h066;
	localparam logic [9:0] IDX_CHAN2_FILTER_TAP_11 = 10'h071;

	// ****************************************
	// Reset values and writable bits
	// ****************************************
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] ROUTE_MASK [NUM_ROUTE_REGS] = '{
		16'h8F0F, 16'h80F0, 16'h800F, 16'h80F0, 16'h8F0F, 16'h80F0
	};
	localparam logic [15:0] TAP_MASK = 16'h8FFF;
	localparam logic [15:0] DEFAULT_PAIR_SEL = 16'hE4E4;

	// ****************************************
	// Where each pair finds its routing field
	// ****************************************
	localparam int PAIR_REG [NUM_PAIRS] = '{0, 0, 1, 2, 3, 4, 4, 5};
	localparam int PAIR_LSB [NUM_PAIRS] = '{0, 8, 4, 0, 4, 0, 8, 4};

	// ****************************************
	// Bus answers and decode regions
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		REGION_NONE = 2'b00,
		REGION_ROUTE = 2'b01,
		REGION_TAP = 2'b10
	} lmfr_region_t;

endpackage

//--- design/lmfr_regs.sv
// Summary of operation
// - Gate bit 15 of the pair one/two register enables both its fields.
// - Pair one/two register: bits 11:8 route pair two, bits 3:0 pair one.
// - Pair three register: bits 7:4 route pair three, only while gated.
// - Pair four register: bits 3:0 route pair four, only while gated.
// - Pair five register: bits 7:4 pick channel five to eight, gated.
// - Pair six/seven register: bits 11:8 pair seven, 3:0 pair six, gated.
// - Pair eight register: bits 7:4 pick channel five to eight, gated.
// - All routing and tap registers read zero after reset.
// - Channel one taps at twelve registers, bit 15 of the first picks custom taps.
// - Each tap register holds a 12-bit coefficient, index in address order.
// - Channel two taps at twelve registers, same layout as channel one.
module lmfr_regs #(
	parameter int SAMPLE_W = 12
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [lmfr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [lmfr_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [lmfr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [lmfr_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [lmfr_pkg::NUM_PAIRS*SAMPLE_W-1:0] chanData,
	output logic [lmfr_pkg::NUM_PAIRS*SAMPLE_W-1:0] serialPairData,
	output logic [2*lmfr_pkg::NUM_PAIRS-1:0] pairChanSel,
	output logic chan1UserTapsSelect,
	output logic chan2UserTapsSelect,
	output logic [lmfr_pkg::NUM_TAPS*lmfr_pkg::TAP_VAL_W-1:0] chan1TapValue,
	output logic [lmfr_pkg::NUM_TAPS*lmfr_pkg::TAP_VAL_W-1:0] chan2TapValue
);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic lmfr_pkg::lmfr_region_t regionOf(
		input logic [9:0] idx
	);
		if (idx >= lmfr_pkg::IDX_LANE_ROUTE_PAIRS_ONE_TWO &&
			idx <= lmfr_pkg::IDX_LANE_ROUTE_PAIR_EIGHT)
			return lmfr_pkg::REGION_ROUTE;
		if (idx >= lmfr_pkg::IDX_CHAN1_FILTER_TAP_0 &&
			idx <= lmfr_pkg::IDX_CHAN2_FILTER_TAP_11)
			return lmfr_pkg::REGION_TAP;
		return lmfr_pkg::REGION_NONE;
	endfunction

	function automatic logic [2:0] routeSlot(input logic [9:0] idx);
		logic [9:0] diff;
		diff = idx - lmfr_pkg::IDX_LANE_ROUTE_PAIRS_ONE_TWO;
		return diff[2:0];
	endfunction

	function automatic logic [4:0] tapSlot(input logic [9:0] idx);
		logic [9:0] diff;
		diff = idx - lmfr_pkg::IDX_CHAN1_FILTER_TAP_0;
		return diff[4:0];
	endfunction

	// Upper byte lanes carry no register bits
	function automatic logic [15:0] mergeStrb(
		input logic [15:0] old,
		input logic [15:0] data,
		input logic [1:0] strb
	);
		logic [15:0] merged;
		merged[15:8] = strb[1] ? data[15:8] : old[15:8];
		merged[7:0] = strb[0] ? data[7:0] : old[7:0];
		return merged;
	endfunction

	// ****************************************
	// Register storage
	// ****************************************
	logic [15:0] routeReg [lmfr_pkg::NUM_ROUTE_REGS];
	logic [15:0] tapReg [2*lmfr_pkg::NUM_TAPS];

	// ****************************************
	// Write channels
	// ****************************************
	logic awHeld;
	logic wHeld;
	logic [lmfr_pkg::AXI_ADDR_W-1:0] awAddrHeld;
	logic [15:0] wDataHeld;
	logic [1:0] wStrbHeld;

	wire logic awTake = s_axi_awvalid && s_axi_awready;
	wire logic wTake = s_axi_wvalid && s_axi_wready;
	wire logic doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire logic next_awHeld = (awHeld || awTake) && !doWrite;
	wire logic next_wHeld = (wHeld || wTake) && !doWrite;

	wire logic [9:0] wIdx = awAddrHeld[lmfr_pkg::AXI_ADDR_W-1:2];
	wire lmfr_pkg::lmfr_region_t wRegion = regionOf(wIdx);
	wire logic [2:0] wRouteSlot = routeSlot(wIdx);
	wire logic [4:0] wTapSlot = tapSlot(wIdx);

	// Unused bits are never stored, so they read back as zero
	wire logic [15:0] next_routeValue =
		mergeStrb(routeReg[wRouteSlot], wDataHeld, wStrbHeld) &
		lmfr_pkg::ROUTE_MASK[wRouteSlot];
	wire logic [15:0] next_tapValue =
		mergeStrb(tapReg[wTapSlot], wDataHeld, wStrbHeld) &
		lmfr_pkg::TAP_MASK;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			awHeld <= 1'h0;
			wHeld <= 1'h0;
			s_axi_awready <= 1'h0;
			s_axi_wready <= 1'h0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			s_axi_awready <= !next_awHeld;
			s_axi_wready <= !next_wHeld;
		end
	end

	// Payload needs no reset: it is only used while held
	always_ff @(posedge sys_clk) begin
		if (awTake) begin
			awAddrHeld <= s_axi_awaddr;
		end
		if (wTake) begin
			wDataHeld <= s_axi_wdata[15:0];
			wStrbHeld <= s_axi_wstrb[1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= lmfr_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp <= (wRegion == lmfr_pkg::REGION_NONE) ?
				lmfr_pkg::RESP_SLVERR : lmfr_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'h0;
		end
	end

	// ****************************************
	// Register update
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < lmfr_pkg::NUM_ROUTE_REGS; i++) begin
				routeReg[i] <= lmfr_pkg::REG_RESET;
			end
			for (int i = 0; i < 2 * lmfr_pkg::NUM_TAPS; i++) begin
				tapReg[i] <= lmfr_pkg::REG_RESET;
			end
		end else if (doWrite && wRegion == lmfr_pkg::REGION_ROUTE) begin
			routeReg[wRouteSlot] <= next_routeValue;
		end else if (doWrite && wRegion == lmfr_pkg::REGION_TAP) begin
			tapReg[wTapSlot] <= next_tapValue;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	wire logic arTake = s_axi_arvalid && s_axi_arready;
	wire logic next_rvalid = arTake || (s_axi_rvalid && !s_axi_rready);
	wire logic [9:0] rIdx = s_axi_araddr[lmfr_pkg::AXI_ADDR_W-1:2];
	wire lmfr_pkg::lmfr_region_t rRegion = regionOf(rIdx);
	wire logic [2:0] rRouteSlot = routeSlot(rIdx);
	wire logic [4:0] rTapSlot = tapSlot(rIdx);
	wire logic [15:0] rValue =
		(rRegion == lmfr_pkg::REGION_ROUTE) ? routeReg[rRouteSlot] :
		(rRegion == lmfr_pkg::REGION_TAP) ? tapReg[rTapSlot] :
		lmfr_pkg::REG_RESET;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid <= 1'h0;
		end else begin
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid <= next_rvalid;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= lmfr_pkg::RESP_OKAY;
		end else if (arTake) begin
			s_axi_rdata <= {16'h0000, rValue};
			s_axi_rresp <= (rRegion == lmfr_pkg::REGION_NONE) ?
				lmfr_pkg::RESP_SLVERR : lmfr_pkg::RESP_OKAY;
		end
	end

	// ****************************************
	// Filter tap outputs
	// ****************************************
	// Select bits of the other eleven registers are stored but unused
	assign chan1UserTapsSelect = tapReg[0][lmfr_pkg::SELECT_BIT];
	assign chan2UserTapsSelect =
		tapReg[lmfr_pkg::NUM_TAPS][lmfr_pkg::SELECT_BIT];

	for (genvar t = 0; t < lmfr_pkg::NUM_TAPS; t++) begin : g_tap
		assign chan1TapValue[t*lmfr_pkg::TAP_VAL_W +: lmfr_pkg::TAP_VAL_W] =
			tapReg[t][lmfr_pkg::TAP_VAL_W-1:0];
		assign chan2TapValue[t*lmfr_pkg::TAP_VAL_W +: lmfr_pkg::TAP_VAL_W] =
			tapReg[lmfr_pkg::NUM_TAPS+t][lmfr_pkg::TAP_VAL_W-1:0];
	end

	// ****************************************
	// Lane routing
	// ****************************************
	// One register stage: a new map shows one cycle after the write
	for (genvar p = 0; p < lmfr_pkg::NUM_PAIRS; p++) begin : g_pair
		localparam int REG_IDX = lmfr_pkg::PAIR_REG[p];
		localparam int LSB = lmfr_pkg::PAIR_LSB[p];
		localparam logic [1:0] DEF_IDX = 2'(p % lmfr_pkg::GROUP_SIZE);
		localparam logic GROUP_HI = (p >= lmfr_pkg::GROUP_SIZE);
		wire logic [1:0] sel;
		wire logic [2:0] srcChan = {GROUP_HI, sel};
		logic [1:0] selQ;
		logic [SAMPLE_W-1:0] dataQ;

		lmfr_route_sel #(
			.DEFAULT_IDX(DEF_IDX)
		) u_sel (
			.code(routeReg[REG_IDX][LSB +: lmfr_pkg::CODE_W]),
			.gate(routeReg[REG_IDX][lmfr_pkg::GATE_BIT]),
			.sel(sel)
		);

		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				selQ <= DEF_IDX;
				dataQ <= '0;
			end else begin
				selQ <= sel;
				dataQ <= chanData[srcChan*SAMPLE_W +: SAMPLE_W];
			end
		end

		assign pairChanSel[2*p +: 2] = selQ;
		assign serialPairData[p*SAMPLE_W +: SAMPLE_W] = dataQ;
	end

	// ****************************************
	// Checks
	// ****************************************
	gate_off_default_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!routeReg[0][lmfr_pkg::GATE_BIT] |=> pairChanSel[3:0] == 4'h4
	) else $error("pairs one and two not default while ungated");

	pair_one_map_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		routeReg[0][lmfr_pkg::GATE_BIT] && routeReg[0][3:0] == 4'h4 &&
		routeReg[0][11:8] == 4'h8
		|=> pairChanSel[1:0] == 2'h2 && pairChanSel[3:2] == 2'h3
	) else $error("pair one or two map wrong");

	pair_three_map_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		routeReg[1][lmfr_pkg::GATE_BIT] && routeReg[1][7:4] == 4'h8
		|=> pairChanSel[5:4] == 2'h3
	) else $error("pair three map wrong");

	pair_four_map_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		routeReg[2][lmfr_pkg::GATE_BIT] && routeReg[2][3:0] == 4'h1
		|=> pairChanSel[7:6] == 2'h0
	) else $error("pair four map wrong");

	pair_five_data_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		routeReg[3][lmfr_pkg::GATE_BIT] && routeReg[3][7:4] == 4'h2
		|=> pairChanSel[9:8] == 2'h1 &&
		serialPairData[4*SAMPLE_W +: SAMPLE_W] ==
		$past(chanData[5*SAMPLE_W +: SAMPLE_W])
	) else $error("pair five not fed from channel six");

	pair_seven_map_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		routeReg[4][lmfr_pkg::GATE_BIT] && routeReg[4][11:8] == 4'h1
		|=> pairChanSel[13:12] == 2'h0
	) else $error("pair seven map wrong");

	pair_eight_off_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!routeReg[5][lmfr_pkg::GATE_BIT] |=> pairChanSel[15:14] == 2'h3
	) else $error("pair eight not default while ungated");

	reset_clear_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!$past(resetn) |-> pairChanSel == lmfr_pkg::DEFAULT_PAIR_SEL &&
		!chan1UserTapsSelect && !chan2UserTapsSelect &&
		chan1TapValue == '0 && chan2TapValue == '0
	) else $error("state not cleared by reset");

	chan1_select_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		doWrite && wIdx == lmfr_pkg::IDX_CHAN1_FILTER_TAP_0 && wStrbHeld[1]
		|=> chan1UserTapsSelect == $past(wDataHeld[15])
	) else $error("channel one select not taken from first tap");

	tap_value_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		doWrite && wIdx == lmfr_pkg::IDX_CHAN1_FILTER_TAP_0 + 10'h003 &&
		wStrbHeld == 2'h3
		|=> chan1TapValue[3*lmfr_pkg::TAP_VAL_W +: lmfr_pkg::TAP_VAL_W] ==
		$past(wDataHeld[11:0])
	) else $error("tap three value misplaced");

	chan2_select_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		doWrite && wIdx == lmfr_pkg::IDX_CHAN2_FILTER_TAP_0 && wStrbHeld[1]
		|=> chan2UserTapsSelect == $past(wDataHeld[15])
	) else $error("channel two select not taken from first tap");

	bad_code_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		routeReg[0][lmfr_pkg::GATE_BIT] && routeReg[0][3:0] == 4'h3
		|=> pairChanSel[1:0] == 2'h0
	) else $error("multi-hot code changed routing");

	other_select_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		doWrite && wIdx == lmfr_pkg::IDX_CHAN1_FILTER_TAP_11
		|=> $stable(chan1UserTapsSelect)
	) else $error("last tap select bit changed selection");

endmodule // lmfr_regs

//--- design/lmfr_route_sel.sv
module lmfr_route_sel #(
	parameter logic [1:0] DEFAULT_IDX = 2'h0
) (
	input wire logic [lmfr_pkg::CODE_W-1:0] code,
	input wire logic gate,
	output logic [1:0] sel
);

	// ****************************************
	// One-hot code to channel index within the group
	// ****************************************
	function automatic logic [2:0] decodeOneHot(input logic [3:0] c);
		unique case (c)
			4'h1: return 3'h4;
			4'h2: return 3'h5;
			4'h4: return 3'h6;
			4'h8: return 3'h7;
			default: return 3'h0;
		endcase
	endfunction

	wire logic [2:0] decoded = decodeOneHot(code);

	// Zero or multi-hot codes would be ambiguous, so keep the default
	assign sel = (gate && decoded[2]) ? decoded[1:0] : DEFAULT_IDX;

endmodule // lmfr_route_sel

//--- sim/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 12;
	logic sys_clk, resetn;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [8*W-1:0] chanData, serialPairData;
	logic [15:0] pairChanSel;
	logic chan1UserTapsSelect, chan2UserTapsSelect;
	logic [143:0] chan1TapValue, chan2TapValue;
	logic [15:0] mdl [0:1023];
	logic [1:0] resp;
	logic [31:0] rd;
	int mismatches, checked, seed, i;

	lmfr_regs #(.SAMPLE_W(W)) u_lmfr_regs (.sys_clk(sys_clk),
		.resetn(resetn), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.chanData(chanData), .serialPairData(serialPairData),
		.pairChanSel(pairChanSel),
		.chan1UserTapsSelect(chan1UserTapsSelect),
		.chan2UserTapsSelect(chan2UserTapsSelect),
		.chan1TapValue(chan1TapValue), .chan2TapValue(chan2TapValue));

	// ****************************************
	// Clock, verdict and watchdog
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		$display("watchdog expired");
		close_out();
	end

	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask

	// ****************************************
	// Model of the register map
	// ****************************************
	function automatic logic [15:0] maskOf(input int idx);
		if (idx >= 'h50 && idx <= 'h55) begin
			return lmfr_pkg::ROUTE_MASK[idx-'h50];
		end
		if (idx >= 'h5A && idx <= 'h71) begin
			return lmfr_pkg::TAP_MASK;
		end
		return 16'h0000;
	endfunction

	// ****************************************
	// AXI4-Lite master, unbounded waits
	// ****************************************
	task automatic axi_write(input int idx, input logic [15:0] d,
		input logic [3:0] strb);
		logic [15:0] bm;
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= {idx[9:0], 2'($random(seed))};
		s_axi_awprot <= 3'($random(seed));
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= {16'($random(seed)), d};
		s_axi_wstrb <= strb;
		s_axi_bready <= 1'b1;
		// No cycle count assumed: only the watchdog ends a stuck wait
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		bm = {{8{strb[1]}}, {8{strb[0]}}};
		mdl[idx] = ((mdl[idx] & ~bm) | (d & bm)) & maskOf(idx);
		check(160'(resp), 160'(maskOf(idx) == 0 ? 2'h2 : 2'h0));
	endtask

	task automatic axi_read(input int idx);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= {idx[9:0], 2'($random(seed))};
		s_axi_arprot <= 3'($random(seed));
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		check(160'(resp), 160'(maskOf(idx) == 0 ? 2'h2 : 2'h0));
		check(160'(rd), 160'({16'h0000, mdl[idx]}));
	endtask

	// Routing and tap outputs against the model, every result
	task automatic check_outputs;
		logic [15:0] r, es;
		logic [8*W-1:0] ed;
		logic [143:0] t1, t2;
		logic [1:0] s;
		for (int k = 0; k < 8; k++) begin
			r = mdl['h50 + lmfr_pkg::PAIR_REG[k]];
			s = 2'(k % 4);
			if (r[15]) begin
				case (r[lmfr_pkg::PAIR_LSB[k] +: 4])
					4'h1: s = 2'h0;
					4'h2: s = 2'h1;
					4'h4: s = 2'h2;
					4'h8: s = 2'h3;
					default: s = 2'(k % 4);
				endcase
			end
			es[2*k +: 2] = s;
			ed[k*W +: W] = chanData[((k/4)*4 + int'(s))*W +: W];
		end
		for (int t = 0; t < 12; t++) begin
			t1[12*t +: 12] = mdl['h5A + t][11:0];
			t2[12*t +: 12] = mdl['h66 + t][11:0];
		end
		check(160'(pairChanSel), 160'(es));
		check(160'(serialPairData), 160'(ed));
		check(160'(chan1TapValue), 160'(t1));
		check(160'(chan2TapValue), 160'(t2));
		check(160'(chan1UserTapsSelect), 160'(mdl['h5A][15]));
		check(160'(chan2UserTapsSelect), 160'(mdl['h66][15]));
	endtask

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int k = 0; k < 1024; k++) mdl[k] = 16'h0000;
		repeat (2) @(posedge sys_clk);
		for (int k = 'h50; k <= 'h71; k++) begin
			if (k < 'h56 || k > 'h59) axi_read(k);
		end
		check_outputs();
		$display("test reset_values done");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		seed = 94;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		chanData = {3{32'($random(seed))}};
		do_reset();
		// Host keeps every reserved bit at zero
		for (int k = 'h50; k <= 'h71; k++) begin
			if (k < 'h56 || k > 'h59) begin
				axi_write(k, 16'($random(seed)) & maskOf(k), 4'hF);
				axi_read(k);
			end
		end
		check_outputs();
		axi_write('h5A, 16'h8123, 4'h1);
		axi_read('h5A);
		$display("test register_rw done");
		for (i = 0; i < 120; i++) begin
			logic [3:0] a, b, c;
			int ri;
			a = ($random(seed) & 1) ? 4'h1 << ($random(seed) & 3)
				: 4'($random(seed));
			b = ($random(seed) & 1) ? 4'h1 << ($random(seed) & 3)
				: 4'($random(seed));
			c = ($random(seed) & 1) ? 4'h1 << ($random(seed) & 3)
				: 4'($random(seed));
			ri = 'h50 + ($unsigned($random(seed)) % 6);
			chanData <= {3{32'($random(seed))}};
			axi_write(ri, {1'($random(seed)), 3'h0, a, b, c} & maskOf(ri),
				4'hF);
			repeat (2) @(posedge sys_clk);
			check_outputs();
		end
		// Directed maps: two different fields in one register, all six registers written; pairs six and eight keep the default
		axi_write('h50, 16'h8804, 4'hF);
		axi_write('h51, 16'h8080, 4'hF);
		axi_write('h52, 16'h8001, 4'hF);
		axi_write('h53, 16'h8020, 4'hF);
		axi_write('h54, 16'h8100, 4'hF);
		axi_write('h55, 16'h0080, 4'hF);
		repeat (2) @(posedge sys_clk);
		check_outputs();
		axi_write('h50, 16'h8003, 4'hF);
		repeat (2) @(posedge sys_clk);
		check_outputs();
		$display("test routing done");
		// Select bit of a later tap register must not pick custom taps
		axi_write('h5A, 16'h0ABC, 4'hF);
		axi_write('h5B, 16'h8001, 4'hF);
		axi_write('h71, 16'h8FFF, 4'hF);
		axi_write('h66, 16'h0000, 4'hF);
		repeat (2) @(posedge sys_clk);
		check_outputs();
		axi_write('h66, 16'h8555, 4'hF);
		repeat (2) @(posedge sys_clk);
		check_outputs();
		$display("test tap_select done");
		axi_write('h56, 16'hFFFF, 4'hF);
		axi_write('h000, 16'hFFFF, 4'hF);
		axi_write('h3FF, 16'hFFFF, 4'hF);
		axi_read('h59);
		axi_read('h72);
		check_outputs();
		$display("test unmapped done");
		do_reset();
		close_out();
	end
endmodule // tb
